// [hw/ncrb_bank.sv]
// network configuration register bank with pixel phase check.
// assumes the register master and the phase source run on CLK_I,
// so neither input is synchronised.
//
// Design decision made here: the plain strobed port.

// Notes on behaviour
// RULE1 - phase below low limit marks pixel invalid
// RULE2 - phase above high limit marks pixel invalid
// RULE3 - control bit 0 enables dhcp, reset clear
// RULE4 - control bit 1 enables udp streaming
// RULE5 - control bit 2 ignores crc on streaming
// RULE6 - mac split over three words, high first
// RULE7 - upper mac words only staged
// RULE8 - lowest mac word write applies mac
// RULE9 - ip split low/high words, defaults given
// RULE10 - ip, mask, low gateway words only staged
// RULE11 - high gateway write applies ip group
// RULE12 - mask high word defaults all ones
// RULE13 - tcp control port register, default 2711
// RULE14 - stream ip staged low, high applies
// RULE15 - streaming udp port register, default 2712
// RULE16 - udp packet size register, default 0578
// RULE17 - commit moves whole group at once
module ncrb_bank
(
   input wire logic CLK_I,
   input wire logic RST_B_I,
   input wire ncrb_pkg::ncrb_req_t REG_REQ_I,
   output logic [ncrb_pkg::DATA_W-1:0] REG_RDATA_O,
   input wire logic PHASE_VALID_I,
   input wire logic [ncrb_pkg::DATA_W-1:0] PHASE_I,
   output logic PIXEL_VALID_O,
   output logic PIXEL_INVALID_O,
   output ncrb_pkg::ncrb_ctrl_t NET_CTRL_O,
   output logic [47:0] MAC_ADDR_O,
   output ncrb_pkg::ncrb_ip_cfg_t IP_CFG_O,
   output logic [31:0] STREAM_IP_O,
   output logic [ncrb_pkg::DATA_W-1:0] TCP_PORT_O,
   output logic [ncrb_pkg::DATA_W-1:0] UDP_PORT_O,
   output logic [ncrb_pkg::DATA_W-1:0] PKT_LEN_O,
   output logic NET_UPDATE_O
);
   import ncrb_pkg::*;

   ncrb_word_t regs [NUM_REGS];
   ncrb_word_t rd_chain [NUM_REGS+1];
   logic [NUM_REGS-1:0] hit;
   logic [NUM_REGS-1:0] wr_hit;
   logic wr;
   logic rd;
   ncrb_word_t wdata;
   logic mac_commit;
   logic ip_commit;
   logic sd_commit;
   logic below;
   logic above;
   logic [47:0] mac;
   ncrb_ip_cfg_t ip_cfg;
   logic [31:0] sd_ip;
   logic update;

   // bus request fields
   assign wr = REG_REQ_I.wr;
   assign rd = REG_REQ_I.rd;
   assign wdata = REG_REQ_I.wdata;

   // address decode, storage and read mux, one slice per register
   assign rd_chain[0] = '0;
   for (genvar i = 0; i < NUM_REGS; i++)
   begin : g_reg
      assign hit[i] = (REG_REQ_I.addr == REG_OFS[i]);
      assign wr_hit[i] = wr & hit[i];
      assign rd_chain[i+1] = rd_chain[i] | (hit[i] ? regs[i] : '0);
      // staged words keep what was written; unused control bits drop
      always_ff @(posedge CLK_I or negedge RST_B_I)
      begin
         if (!RST_B_I)
            regs[i] <= REG_RST[i];
         else if (wr_hit[i])
            regs[i] <= wdata & REG_MASK[i];
      end
   end

   // read data for one cycle only; unmapped reads give zero
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         REG_RDATA_O <= '0;
      else
         REG_RDATA_O <= rd ? rd_chain[NUM_REGS] : '0;
   end

   // commit strobes
   assign mac_commit = wr_hit[I_MAC_L]; // [RULE8]
   assign ip_commit = wr_hit[I_GW_HI]; // [RULE11]
   assign sd_commit = wr_hit[I_SD_HI]; // [RULE14]

   // active settings move only on their commit word, whole group in
   // one edge; the commit word itself is taken from the bus so the
   // network side never sees the old low/high mix
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         mac <= ACT_MAC_RST;
         ip_cfg <= ACT_IP_RST;
         sd_ip <= ACT_SD_RST;
         update <= 1'b0;
      end
      else
      begin
         if (mac_commit)
            mac <= {regs[I_MAC_U], regs[I_MAC_M], wdata}; // [RULE6] [RULE7] [RULE17]
         if (ip_commit)
            ip_cfg <= {regs[I_IP_HI], regs[I_IP_LO], regs[I_NM_HI], regs[I_NM_LO],
               wdata, regs[I_GW_LO]}; // [RULE9] [RULE10] [RULE12] [RULE17]
         if (sd_commit)
            sd_ip <= {wdata, regs[I_SD_LO]}; // [RULE14] [RULE17]
         update <= mac_commit | ip_commit | sd_commit;
      end
   end

   // pixel check against both limits, one cycle of latency
   assign below = PHASE_I < regs[I_PH_LO]; // [RULE1]
   assign above = PHASE_I > regs[I_PH_HI]; // [RULE2]
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         PIXEL_VALID_O <= 1'b0;
         PIXEL_INVALID_O <= 1'b0;
      end
      else
      begin
         PIXEL_VALID_O <= PHASE_VALID_I;
         PIXEL_INVALID_O <= PHASE_VALID_I & (below | above); // [RULE1] [RULE2]
      end
   end

   // outputs straight from flops
   assign NET_CTRL_O.dhcp_en = regs[I_CTRL][CTRL_DHCP_BIT]; // [RULE3]
   assign NET_CTRL_O.udp_en = regs[I_CTRL][CTRL_UDP_BIT]; // [RULE4]
   assign NET_CTRL_O.crc_ignore = regs[I_CTRL][CTRL_CRC_BIT]; // [RULE5]
   assign MAC_ADDR_O = mac;
   assign IP_CFG_O = ip_cfg;
   assign STREAM_IP_O = sd_ip;
   assign TCP_PORT_O = regs[I_TCP]; // [RULE13]
   assign UDP_PORT_O = regs[I_UDP]; // [RULE15]
   assign PKT_LEN_O = regs[I_PKT]; // [RULE16]
   assign NET_UPDATE_O = update;

   // checks; all on CLK_I, off during reset
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_B_I);

   property p_low_inv;
      PHASE_VALID_I && (PHASE_I < regs[I_PH_LO]) |=> PIXEL_INVALID_O && PIXEL_VALID_O;
   endproperty
   a_low_inv: assert property (p_low_inv) else $error("low phase not invalid"); // [RULE1]

   property p_high_inv;
      PHASE_VALID_I && (PHASE_I > regs[I_PH_HI]) |=> PIXEL_INVALID_O;
   endproperty
   a_high_inv: assert property (p_high_inv) else $error("high phase not invalid"); // [RULE2]

   property p_in_range;
      PHASE_VALID_I && !below && !above |=> !PIXEL_INVALID_O;
   endproperty
   a_in_range: assert property (p_in_range) else $error("good pixel invalid"); // [RULE2]

   property p_dhcp;
      wr_hit[I_CTRL] |=> NET_CTRL_O.dhcp_en == $past(wdata[0]);
   endproperty
   a_dhcp: assert property (p_dhcp) else $error("dhcp enable wrong"); // [RULE3]

   property p_udp;
      wr_hit[I_CTRL] |=> NET_CTRL_O.udp_en == $past(wdata[1]);
   endproperty
   a_udp: assert property (p_udp) else $error("udp enable wrong"); // [RULE4]

   property p_crc;
      wr_hit[I_CTRL] |=> NET_CTRL_O.crc_ignore == $past(wdata[2]) && regs[I_CTRL][15:3] == '0;
   endproperty
   a_crc: assert property (p_crc) else $error("crc ignore wrong"); // [RULE5]

   property p_mac_order;
      wr_hit[I_MAC_U] ##1 wr_hit[I_MAC_M] ##1 wr_hit[I_MAC_L]
         |=> MAC_ADDR_O == {$past(wdata, 3), $past(wdata, 2), $past(wdata)};
   endproperty
   a_mac_order: assert property (p_mac_order) else $error("mac byte order wrong"); // [RULE6]

   property p_mac_hold;
      wr_hit[I_MAC_U] || wr_hit[I_MAC_M] |=> $stable(MAC_ADDR_O);
   endproperty
   a_mac_hold: assert property (p_mac_hold) else $error("mac moved early"); // [RULE7]

   property p_mac_commit;
      mac_commit |=> MAC_ADDR_O[15:0] == $past(wdata) && NET_UPDATE_O;
   endproperty
   a_mac_commit: assert property (p_mac_commit) else $error("mac not applied"); // [RULE8]

   property p_ip_words;
      ip_commit |=> IP_CFG_O.ip == {$past(regs[I_IP_HI]), $past(regs[I_IP_LO])};
   endproperty
   a_ip_words: assert property (p_ip_words) else $error("ip not applied"); // [RULE9]

   property p_ip_hold;
      wr && !ip_commit |=> $stable(IP_CFG_O);
   endproperty
   a_ip_hold: assert property (p_ip_hold) else $error("ip group moved early"); // [RULE10]

   property p_gw_commit;
      ip_commit |=> IP_CFG_O.gw == {$past(wdata), $past(regs[I_GW_LO])};
   endproperty
   a_gw_commit: assert property (p_gw_commit) else $error("gateway not applied"); // [RULE11]

   property p_mask;
      ip_commit |=> IP_CFG_O.mask == {$past(regs[I_NM_HI]), $past(regs[I_NM_LO])};
   endproperty
   a_mask: assert property (p_mask) else $error("mask not applied"); // [RULE12]

   property p_tcp;
      wr_hit[I_TCP] |=> TCP_PORT_O == $past(wdata) ##1 $stable(TCP_PORT_O) || $past(wr);
   endproperty
   a_tcp: assert property (p_tcp) else $error("tcp port wrong"); // [RULE13]

   property p_stream;
      wr_hit[I_SD_LO] |=> $stable(STREAM_IP_O);
   endproperty
   a_stream: assert property (p_stream) else $error("stream ip moved early"); // [RULE14]

   property p_stream_apply;
      sd_commit |=> STREAM_IP_O == {$past(wdata), $past(regs[I_SD_LO])};
   endproperty
   a_stream_apply: assert property (p_stream_apply) else $error("stream ip not applied"); // [RULE14]

   property p_udp_port;
      wr_hit[I_UDP] |=> UDP_PORT_O == $past(wdata);
   endproperty
   a_udp_port: assert property (p_udp_port) else $error("udp port wrong"); // [RULE15]

   property p_pkt;
      wr_hit[I_PKT] |=> PKT_LEN_O == $past(wdata);
   endproperty
   a_pkt: assert property (p_pkt) else $error("packet size wrong"); // [RULE16]

   property p_atomic;
      !ip_commit && !mac_commit && !sd_commit |=> !NET_UPDATE_O && $stable(IP_CFG_O)
         && $stable(MAC_ADDR_O) && $stable(STREAM_IP_O);
   endproperty
   a_atomic: assert property (p_atomic) else $error("settings moved without commit"); // [RULE17]

   property p_read;
      rd && hit[I_CTRL] |=> REG_RDATA_O == $past(regs[I_CTRL]) ##1 (REG_RDATA_O == '0 || $past(rd));
   endproperty
   a_read: assert property (p_read) else $error("read data wrong");

   // main scenarios
   c_mac: cover property (wr_hit[I_MAC_U] ##1 wr_hit[I_MAC_M] ##1 mac_commit);
   c_ip: cover property (wr_hit[I_IP_LO] ##[1:8] ip_commit);
   c_stream: cover property (wr_hit[I_SD_LO] ##2 sd_commit);
   c_pix: cover property (PHASE_VALID_I && below ##1 PHASE_VALID_I && above);

endmodule

// [hw/ncrb_pkg.sv]
// package for the network configuration register bank:
// offsets, reset values, field positions and carrier types.
// assumes a 10-bit word address and 16-bit registers.
package ncrb_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 17;

   typedef logic [DATA_W-1:0] ncrb_word_t;
   typedef logic [ADDR_W-1:0] ncrb_addr_t;

   // register bus request, one strobe at a time
   typedef struct packed {
      logic wr;
      logic rd;
      ncrb_addr_t addr;
      ncrb_word_t wdata;
   } ncrb_req_t;

   // active address settings, changed only by a commit
   typedef struct packed {
      logic [31:0] ip;
      logic [31:0] mask;
      logic [31:0] gw;
   } ncrb_ip_cfg_t;

   typedef struct packed {
      logic crc_ignore;
      logic udp_en;
      logic dhcp_en;
   } ncrb_ctrl_t;

   // register offsets
   localparam ncrb_addr_t OFS_PH_LO = 10'h197;
   localparam ncrb_addr_t OFS_PH_HI = 10'h198;
   localparam ncrb_addr_t OFS_CTRL = 10'h240;
   localparam ncrb_addr_t OFS_MAC_U = 10'h241;
   localparam ncrb_addr_t OFS_MAC_M = 10'h242;
   localparam ncrb_addr_t OFS_MAC_L = 10'h243;
   localparam ncrb_addr_t OFS_IP_LO = 10'h244;
   localparam ncrb_addr_t OFS_IP_HI = 10'h245;
   localparam ncrb_addr_t OFS_NM_LO = 10'h246;
   localparam ncrb_addr_t OFS_NM_HI = 10'h247;
   localparam ncrb_addr_t OFS_GW_LO = 10'h248;
   localparam ncrb_addr_t OFS_GW_HI = 10'h249;
   localparam ncrb_addr_t OFS_TCP = 10'h24B;
   localparam ncrb_addr_t OFS_SD_LO = 10'h24C;
   localparam ncrb_addr_t OFS_SD_HI = 10'h24D;
   localparam ncrb_addr_t OFS_UDP = 10'h24E;
   localparam ncrb_addr_t OFS_PKT = 10'h259;

   // reset values
   localparam ncrb_word_t RST_PH_LO = 16'h0000;
   localparam ncrb_word_t RST_PH_HI = 16'h0000;
   localparam ncrb_word_t RST_CTRL = 16'h0006;
   localparam ncrb_word_t RST_MAC_U = 16'h0000;
   localparam ncrb_word_t RST_MAC_M = 16'h0000;
   localparam ncrb_word_t RST_MAC_L = 16'h0000;
   localparam ncrb_word_t RST_IP_LO = 16'h000A;
   localparam ncrb_word_t RST_IP_HI = 16'hC0A8;
   localparam ncrb_word_t RST_NM_LO = 16'h0000;
   localparam ncrb_word_t RST_NM_HI = 16'hFFFF;
   localparam ncrb_word_t RST_GW_LO = 16'h0001;
   localparam ncrb_word_t RST_GW_HI = 16'hC0A8;
   localparam ncrb_word_t RST_TCP = 16'h2711;
   localparam ncrb_word_t RST_SD_LO = 16'h0001;
   localparam ncrb_word_t RST_SD_HI = 16'hE000;
   localparam ncrb_word_t RST_UDP = 16'h2712;
   localparam ncrb_word_t RST_PKT = 16'h0578;

   // control field positions and implemented bits
   localparam int CTRL_DHCP_BIT = 0;
   localparam int CTRL_UDP_BIT = 1;
   localparam int CTRL_CRC_BIT = 2;
   localparam ncrb_word_t CTRL_MASK = 16'h0007;
   localparam ncrb_word_t FULL_MASK = 16'hFFFF;

   // register indices into the bank
   localparam int I_PH_LO = 0;
   localparam int I_PH_HI = 1;
   localparam int I_CTRL = 2;
   localparam int I_MAC_U = 3;
   localparam int I_MAC_M = 4;
   localparam int I_MAC_L = 5;
   localparam int I_IP_LO = 6;
   localparam int I_IP_HI = 7;
   localparam int I_NM_LO = 8;
   localparam int I_NM_HI = 9;
   localparam int I_GW_LO = 10;
   localparam int I_GW_HI = 11;
   localparam int I_TCP = 12;
   localparam int I_SD_LO = 13;
   localparam int I_SD_HI = 14;
   localparam int I_UDP = 15;
   localparam int I_PKT = 16;

   localparam ncrb_addr_t REG_OFS [NUM_REGS] = '{OFS_PH_LO, OFS_PH_HI, OFS_CTRL,
      OFS_MAC_U, OFS_MAC_M, OFS_MAC_L, OFS_IP_LO, OFS_IP_HI, OFS_NM_LO, OFS_NM_HI,
      OFS_GW_LO, OFS_GW_HI, OFS_TCP, OFS_SD_LO, OFS_SD_HI, OFS_UDP, OFS_PKT};
   localparam ncrb_word_t REG_RST [NUM_REGS] = '{RST_PH_LO, RST_PH_HI, RST_CTRL,
      RST_MAC_U, RST_MAC_M, RST_MAC_L, RST_IP_LO, RST_IP_HI, RST_NM_LO, RST_NM_HI,
      RST_GW_LO, RST_GW_HI, RST_TCP, RST_SD_LO, RST_SD_HI, RST_UDP, RST_PKT};
   localparam ncrb_word_t REG_MASK [NUM_REGS] = '{FULL_MASK, FULL_MASK, CTRL_MASK,
      FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK,
      FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK, FULL_MASK};

   // active values after reset
   localparam logic [47:0] ACT_MAC_RST = {RST_MAC_U, RST_MAC_M, RST_MAC_L};
   localparam ncrb_ip_cfg_t ACT_IP_RST = {RST_IP_HI, RST_IP_LO, RST_NM_HI, RST_NM_LO,
      RST_GW_HI, RST_GW_LO};
   localparam logic [31:0] ACT_SD_RST = {RST_SD_HI, RST_SD_LO};

endpackage

// [verification/ncrb_bank_tb.sv]
// self-checking bench for the network configuration register bank.
// assumes ncrb_pkg is compiled first; the bench drives every port itself.
module network_config_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ncrb_pkg::*;

   logic clk = 1'b0;
   logic rst_b;
   ncrb_req_t req;
   logic phase_valid;
   ncrb_word_t phase;
   ncrb_word_t rdata, tcp_port, udp_port, pkt_len;
   logic pix_valid, pix_invalid, net_update;
   ncrb_ctrl_t net_ctrl;
   logic [47:0] mac_addr, mac_exp;
   ncrb_ip_cfg_t ip_cfg, ip_exp;
   logic [31:0] stream_ip;
   int n_mismatch = 0;
   int num_checks = 0;
   integer seed = 25;
   ncrb_word_t lo = '0, hi = '0, d, w[6];

   // 20 MHz
   always #25 clk = ~clk;

   ncrb_bank ncrb_bank_i (.CLK_I(clk), .RST_B_I(rst_b), .REG_REQ_I(req), .REG_RDATA_O(rdata),
      .PHASE_VALID_I(phase_valid), .PHASE_I(phase), .PIXEL_VALID_O(pix_valid),
      .PIXEL_INVALID_O(pix_invalid), .NET_CTRL_O(net_ctrl), .MAC_ADDR_O(mac_addr),
      .IP_CFG_O(ip_cfg), .STREAM_IP_O(stream_ip), .TCP_PORT_O(tcp_port), .UDP_PORT_O(udp_port),
      .PKT_LEN_O(pkt_len), .NET_UPDATE_O(net_update));

   task automatic complete_run;
      if (n_mismatch == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // wide enough for the whole address group
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask

   // one-cycle strobes; returns just after the sampling edge
   task automatic wr(input ncrb_addr_t a, input ncrb_word_t v);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, v};
      @(posedge clk);
      req <= '0;
      #1;
   endtask

   // read data only stand in the cycle after the strobe
   task automatic rd(input ncrb_addr_t a, output ncrb_word_t v);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      v = rdata;
   endtask

   // strict limits: equal to a limit stays valid
   function automatic logic exp_invalid(input ncrb_word_t p);
      return (p < lo) || (p > hi);
   endfunction

   task automatic pix(input ncrb_word_t p);
      @(posedge clk);
      phase_valid <= 1'b1;
      phase <= p;
      @(posedge clk);
      phase_valid <= 1'b0;
      #1;
      chk(pix_valid, 1'b1);
      chk(pix_invalid, exp_invalid(p));
   endtask

   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #(20000 * 50);
      n_mismatch++;
      complete_run;
   end

   initial
   begin
      req = '0;
      phase_valid = 1'b0;
      phase = '0;
      rst_b = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      // reset values of the whole table and of the active outputs except the mac address
      for (int i = 0; i < NUM_REGS; i++)
      begin
         rd(REG_OFS[i], d);
         chk(d, REG_RST[i] & REG_MASK[i]);
      end
      chk(net_ctrl, 3'b110);
      chk(ip_cfg, ACT_IP_RST);
      chk(stream_ip, ACT_SD_RST);
      chk({tcp_port, udp_port, pkt_len}, {RST_TCP, RST_UDP, RST_PKT});
      // limits reset to zero, so only phase zero passes
      pix(16'h0000);
      pix(16'h0001);
      // random limits with boundary phases around them
      repeat (4)
      begin
         lo = $random(seed);
         hi = $random(seed);
         wr(OFS_PH_LO, lo);
         wr(OFS_PH_HI, hi);
         pix(lo - 16'h0001);
         pix(lo);
         pix(hi);
         pix(hi + 16'h0001);
         pix($random(seed));
      end
      // every control code, upper junk bits must be dropped
      for (int c = 0; c < 8; c++)
      begin
         d = $random(seed);
         wr(OFS_CTRL, {d[15:3], c[2:0]});
         chk(net_ctrl, c[2:0]);
         rd(OFS_CTRL, d);
         chk(d, {13'h0000, c[2:0]});
      end
      // hardware address: two staged words, third commits
      mac_exp = ACT_MAC_RST;
      repeat (3)
      begin
         for (int k = 0; k < 3; k++)
            w[k] = $random(seed);
         wr(OFS_MAC_U, w[0]);
         chk(net_update, 1'b0);
         wr(OFS_MAC_M, w[1]);
         rd(OFS_MAC_U, d);
         chk({d, mac_addr}, {w[0], mac_exp});
         wr(OFS_MAC_L, w[2]);
         mac_exp = {w[0], w[1], w[2]};
         chk({net_update, mac_addr}, {1'b1, mac_exp});
         @(posedge clk);
         #1;
         chk(net_update, 1'b0);
      end
      // back-to-back burst of the three words, no idle cycle between strobes
      for (int k = 3; k < 6; k++)
         w[k] = $random(seed);
      @(posedge clk);
      req <= '{1'b1, 1'b0, OFS_MAC_U, w[3]};
      @(posedge clk);
      req <= '{1'b1, 1'b0, OFS_MAC_M, w[4]};
      @(posedge clk);
      req <= '{1'b1, 1'b0, OFS_MAC_L, w[5]};
      @(posedge clk);
      req <= '0;
      #1;
      chk({net_update, mac_addr}, {1'b1, w[3], w[4], w[5]});
      // address group: five staged words, high router word commits
      ip_exp = ACT_IP_RST;
      repeat (3)
      begin
         for (int k = 0; k < 6; k++)
            w[k] = $random(seed);
         for (int k = 0; k < 5; k++)
         begin
            wr(OFS_IP_LO + ncrb_addr_t'(k), w[k]);
            chk({net_update, ip_cfg}, {1'b0, ip_exp});
         end
         rd(OFS_NM_HI, d);
         chk(d, w[3]);
         wr(OFS_GW_HI, w[5]);
         ip_exp = {w[1], w[0], w[3], w[2], w[5], w[4]};
         chk({net_update, ip_cfg}, {1'b1, ip_exp});
      end
      // stream destination: low staged, high commits
      w[0] = $random(seed);
      w[1] = $random(seed);
      wr(OFS_SD_LO, w[0]);
      chk({net_update, stream_ip}, {1'b0, ACT_SD_RST});
      wr(OFS_SD_HI, w[1]);
      chk({net_update, stream_ip}, {1'b1, w[1], w[0]});
      // plain port and size registers
      for (int k = 0; k < 3; k++)
         w[k] = $random(seed);
      wr(OFS_TCP, w[0]);
      wr(OFS_UDP, w[1]);
      wr(OFS_PKT, w[2]);
      chk({tcp_port, udp_port, pkt_len}, {w[0], w[1], w[2]});
      rd(OFS_PKT, d);
      chk(d, w[2]);
      // unmapped holes read zero and keep nothing
      wr(10'h24A, 16'hFFFF);
      rd(10'h24A, d);
      chk(d, 16'h0000);
      rd(10'h3FF, d);
      chk(d, 16'h0000);
      @(posedge clk);
      #1;
      chk(rdata, 16'h0000);
      complete_run;
   end
endmodule
